// ===== inc/oobrts_pkg.sv
// oobrts_pkg: shared constants for the out-of-band serial transmitter with rts policy.
// assumes a 100 MHz system clock; all rates derive from it.
package oobrts_pkg;
  // ==========================================================================
  // clock and line rates
  // ==========================================================================
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned BAUD_1200 = 1200;
  localparam int unsigned BAUD_2400 = 2400;
  localparam int unsigned BAUD_9600 = 9600;
  localparam int unsigned BAUD_19200 = 19200;
  localparam int unsigned BAUD_38400 = 38400;
  localparam int unsigned DIV_W = 17;
  // rounded to nearest whole cycle per bit
  localparam logic [DIV_W-1:0] DIV_1200 = DIV_W'((CLK_HZ + BAUD_1200 / 2) / BAUD_1200);
  localparam logic [DIV_W-1:0] DIV_2400 = DIV_W'((CLK_HZ + BAUD_2400 / 2) / BAUD_2400);
  localparam logic [DIV_W-1:0] DIV_9600 = DIV_W'((CLK_HZ + BAUD_9600 / 2) / BAUD_9600);
  localparam logic [DIV_W-1:0] DIV_19200 = DIV_W'((CLK_HZ + BAUD_19200 / 2) / BAUD_19200);
  localparam logic [DIV_W-1:0] DIV_38400 = DIV_W'((CLK_HZ + BAUD_38400 / 2) / BAUD_38400);
  // ==========================================================================
  // rate select codes
  // ==========================================================================
  localparam logic [2:0] RATE_1200 = 3'h0;
  localparam logic [2:0] RATE_2400 = 3'h1;
  localparam logic [2:0] RATE_9600 = 3'h2;
  localparam logic [2:0] RATE_19200 = 3'h3;
  localparam logic [2:0] RATE_38400 = 3'h4;
  localparam logic [2:0] RATE_RST = RATE_9600;
  localparam logic RTS_GATE_RST = 1'b0;
  // ==========================================================================
  // frame
  // ==========================================================================
  localparam int unsigned DATA_BITS = 8;
  localparam logic [3:0] LAST_BIT = 4'h9;
  localparam int unsigned FIFO_DEPTH = 16;
  // ==========================================================================
  // transmitter states
  // ==========================================================================
  typedef enum logic [2:0] {
    OOBRTS_IDLE = 3'b001,
    OOBRTS_LOAD = 3'b010,
    OOBRTS_SHIFT = 3'b100
  } oobrts_tx_state_t;
endpackage

// ===== rtl/oobrts_fifo.sv
// oobrts_fifo: synchronous fifo with valid/ready on both sides.
// assumes single clock and synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module oobrts_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // sync reset
  input wire logic [WIDTH-1:0] in_data_i, // write data
  input wire logic in_valid_i, // write request
  output logic in_ready_o, // space available
  output logic [WIDTH-1:0] out_data_o, // head word
  output logic out_valid_o, // data available
  input wire logic out_ready_i // pop
);
  localparam int unsigned AW = $clog2(DEPTH);
  // ==========================================================================
  // storage and pointers
  // ==========================================================================
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push, pop;

  assign in_ready_o = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o = mem_r[rd_r];

  always_comb begin
    push = in_valid_i && in_ready_o;
    pop = out_valid_o && out_ready_i;
    wr_nxt = push ? AW'(wr_r + 1'b1) : wr_r;
    rd_nxt = pop ? AW'(rd_r + 1'b1) : rd_r;
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = (AW+1)'(cnt_r + 1'b1);
    end else if (pop && !push) begin
      cnt_nxt = (AW+1)'(cnt_r - 1'b1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else begin
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // storage needs no reset; only words under the count are ever read
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_r[wr_r] <= in_data_i;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/oobrts_baud.sv
// oobrts_baud: bit-rate enable divider for the five line rates.
// assumes rate_i is held steady by the parent while a frame is in flight.
`timescale 1ns/1ps
`default_nettype none
module oobrts_baud
  import oobrts_pkg::*;
(
  input wire logic clk_i, // system clock
  input wire logic rst_i, // sync reset
  input wire logic run_i, // count while high
  input wire logic [2:0] rate_i, // rate select code
  output logic tick_o // one-cycle bit pulse
);
  // ==========================================================================
  // rate decode
  // ==========================================================================
  function automatic logic [DIV_W-1:0] rate_div(input logic [2:0] code);
    logic [DIV_W-1:0] d;
    d = DIV_9600;
    if (code == RATE_1200) begin
      d = DIV_1200;
    end else if (code == RATE_2400) begin
      d = DIV_2400;
    end else if (code == RATE_19200) begin
      d = DIV_19200;
    end else if (code == RATE_38400) begin
      d = DIV_38400;
    end
    return d;
  endfunction

  logic [DIV_W-1:0] cnt_r, cnt_nxt;
  logic tick_r, tick_nxt;

  assign tick_o = tick_r;

  always_comb begin
    cnt_nxt = '0;
    tick_nxt = 1'b0;
    if (run_i) begin
      if (cnt_r >= DIV_W'(rate_div(rate_i) - 1'b1)) begin
        tick_nxt = 1'b1;
      end else begin
        cnt_nxt = DIV_W'(cnt_r + 1'b1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= '0;
      tick_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/oobrts_tx.sv
// oobrts_tx: out-of-band management port transmitter with rts policy.
// assumes firmware drives settings and bytes synchronously; the far end
// runs at the same line rate and 8n1 framing.
`timescale 1ns/1ps
`default_nettype none
module oobrts_tx
  import oobrts_pkg::*;
#(
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  input wire logic clk_i, // system clock 100 MHz
  input wire logic rst_i, // sync reset, active high
  input wire logic cfg_we_i, // settings write strobe
  input wire logic [2:0] cfg_rate_i, // rate code
  input wire logic cfg_gate_i, // rts gating enable
  input wire logic selftest_done_i, // self-test finished pulse
  input wire logic [DATA_BITS-1:0] tx_data_i, // byte to send
  input wire logic tx_valid_i, // byte offered
  output logic tx_ready_o, // byte accepted
  output logic txd_o, // serial line out
  output logic rts_o, // request to send, active high
  output logic [2:0] rate_o, // rate in effect
  output logic gate_o, // gating in effect
  output logic busy_o // frame in flight or queued
);
  // ==========================================================================
  // settings
  // ==========================================================================
  logic [2:0] rate_r, rate_nxt, pend_rate_r, pend_rate_nxt;
  logic gate_r, gate_nxt, st_done_r, st_done_nxt;
  logic pend_r, pend_nxt;

  function automatic logic rate_ok(input logic [2:0] code);
    return (code <= RATE_38400);
  endfunction

  oobrts_tx_state_t st_r, st_nxt;

  always_comb begin
    rate_nxt = rate_r;
    pend_rate_nxt = pend_rate_r;
    pend_nxt = pend_r;
    gate_nxt = gate_r;
    st_done_nxt = st_done_r;
    // rate changes are held back until the line is idle so no frame is torn
    if (cfg_we_i && rate_ok(cfg_rate_i)) begin
      pend_rate_nxt = cfg_rate_i;
      pend_nxt = 1'b1;
    end else if (pend_r && (st_r == OOBRTS_IDLE)) begin
      rate_nxt = pend_rate_r;
      pend_nxt = 1'b0;
    end
    if (cfg_we_i) begin
      gate_nxt = cfg_gate_i;
    end
    // self-test completion wins over the gating bit of a simultaneous settings write; its rate code is still taken
    if (selftest_done_i) begin
      gate_nxt = 1'b0;
      st_done_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rate_r <= RATE_RST;
      pend_rate_r <= RATE_RST;
      pend_r <= 1'b0;
      gate_r <= RTS_GATE_RST;
      st_done_r <= 1'b0;
    end else begin
      rate_r <= rate_nxt;
      pend_rate_r <= pend_rate_nxt;
      pend_r <= pend_nxt;
      gate_r <= gate_nxt;
      st_done_r <= st_done_nxt;
    end
  end

  // ==========================================================================
  // queue and bit clock
  // ==========================================================================
  localparam int unsigned QW = $clog2(DEPTH) + 1;
  logic [DATA_BITS-1:0] q_data;
  logic q_valid, q_pop, tick, take;
  logic [QW-1:0] occ_r, occ_nxt;
  logic ready_r, ready_nxt;

  oobrts_fifo #(
    .WIDTH(DATA_BITS),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_data_i(tx_data_i),
    .in_valid_i(tx_valid_i),
    .in_ready_o(),
    .out_data_o(q_data),
    .out_valid_o(q_valid),
    .out_ready_i(q_pop)
  );

  // a shadow of the queue count lets ready come from a flop while still
  // agreeing cycle for cycle with the queue's own push gating
  always_comb begin
    take = tx_valid_i && ready_r;
    occ_nxt = occ_r;
    if (take && !q_pop) begin
      occ_nxt = QW'(occ_r + 1'b1);
    end else if (q_pop && !take) begin
      occ_nxt = QW'(occ_r - 1'b1);
    end
    ready_nxt = (occ_nxt != QW'(DEPTH));
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      occ_r <= '0;
      ready_r <= 1'b1;
    end else begin
      occ_r <= occ_nxt;
      ready_r <= ready_nxt;
    end
  end

  assign tx_ready_o = ready_r;

  oobrts_baud u_baud (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(st_r == OOBRTS_SHIFT),
    .rate_i(rate_r),
    .tick_o(tick)
  );

  // ==========================================================================
  // transmitter
  // ==========================================================================
  logic [DATA_BITS+1:0] sh_r, sh_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic txd_r, txd_nxt, rts_r, rts_nxt, busy_r, busy_nxt;

  always_comb begin
    st_nxt = st_r;
    sh_nxt = sh_r;
    bit_nxt = bit_r;
    txd_nxt = txd_r;
    q_pop = 1'b0;
    case (st_r)
      OOBRTS_IDLE: begin
        txd_nxt = 1'b1;
        if (q_valid && !pend_r) begin
          q_pop = 1'b1;
          sh_nxt = {1'b1, q_data, 1'b0};
          st_nxt = OOBRTS_LOAD;
        end
      end
      OOBRTS_LOAD: begin
        txd_nxt = sh_r[0];
        sh_nxt = {1'b1, sh_r[DATA_BITS+1:1]};
        bit_nxt = '0;
        st_nxt = OOBRTS_SHIFT;
      end
      OOBRTS_SHIFT: begin
        if (tick) begin
          if (bit_r == LAST_BIT) begin
            // stop bit has now lasted a full bit time
            st_nxt = OOBRTS_IDLE;
          end else begin
            txd_nxt = sh_r[0];
            sh_nxt = {1'b1, sh_r[DATA_BITS+1:1]};
            bit_nxt = 4'(bit_r + 1'b1);
          end
        end
      end
      default: begin
        st_nxt = OOBRTS_IDLE;
      end
    endcase
    busy_nxt = q_valid || (st_nxt != OOBRTS_IDLE);
    if (gate_r) begin
      rts_nxt = busy_nxt;
    end else begin
      rts_nxt = st_done_r || selftest_done_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= OOBRTS_IDLE;
      sh_r <= '1;
      bit_r <= '0;
      txd_r <= 1'b1;
      rts_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      sh_r <= sh_nxt;
      bit_r <= bit_nxt;
      txd_r <= txd_nxt;
      rts_r <= rts_nxt;
      busy_r <= busy_nxt;
    end
  end

  assign txd_o = txd_r;
  assign rts_o = rts_r;
  assign rate_o = rate_r;
  assign gate_o = gate_r;
  assign busy_o = busy_r;
endmodule
`default_nettype wire

// ===== verification/oobrts_tx_properties.sv
// oobrts_tx_properties: port checks of rate and rts policy.
// assumes binding onto oobrts_tx; sync active-high reset.
`timescale 1ns/1ps
`default_nettype none
module oobrts_tx_properties
  import oobrts_pkg::*;
#(
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  input wire logic clk_i, // clock
  input wire logic rst_i, // reset
  input wire logic cfg_we_i, // settings write
  input wire logic [2:0] cfg_rate_i, // rate code
  input wire logic cfg_gate_i, // gating
  input wire logic selftest_done_i, // self-test done
  input wire logic [DATA_BITS-1:0] tx_data_i, // byte
  input wire logic tx_valid_i, // byte offered
  input wire logic tx_ready_o, // room
  input wire logic txd_o, // line
  input wire logic rts_o, // rts
  input wire logic [2:0] rate_o, // rate in use
  input wire logic gate_o, // gating in use
  input wire logic busy_o // busy
);
  // =====
  // helper: length of the current high run on the line
  logic [DIV_W-1:0] hi_cnt_r, hi_cnt_nxt;

  function automatic logic [DIV_W-1:0] bit_div(input logic [2:0] code);
    case (code)
      RATE_1200: return DIV_1200;
      RATE_2400: return DIV_2400;
      RATE_19200: return DIV_19200;
      RATE_38400: return DIV_38400;
      default: return DIV_9600;
    endcase
  endfunction

  always_comb begin
    hi_cnt_nxt = hi_cnt_r;
    if (!txd_o) begin
      hi_cnt_nxt = '0;
    end else if (hi_cnt_r != '1) begin
      hi_cnt_nxt = DIV_W'(hi_cnt_r + 1'b1);
    end
  end

  // the idle line around reset counts as a long high run
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hi_cnt_r <= '1;
    end else begin
      hi_cnt_r <= hi_cnt_nxt;
    end
  end

  // =====
  // properties
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  rate_legal_a: assert property (rate_o <= RATE_38400)
    else $error("rate code out of range");
  rate_default_a: assert property ($fell(rst_i) |-> rate_o == RATE_9600)
    else $error("rate after reset wrong");
  gate_default_a: assert property ($fell(rst_i) |-> !gate_o && !rts_o)
    else $error("gating or rts after reset wrong");
  selftest_rts_a: assert property (selftest_done_i |=> !gate_o && rts_o)
    else $error("self-test did not force rts on");
  ungated_hold_a: assert property (!gate_o && rts_o && !cfg_we_i |=> rts_o)
    else $error("rts dropped while ungated");
  gated_idle_a: assert property (gate_o && $past(gate_o) && !busy_o && !$past(busy_o)
    |-> !rts_o)
    else $error("rts on while gated and idle");
  gated_send_a: assert property (gate_o && !txd_o |-> rts_o)
    else $error("rts off during gated frame");
  stop_first_a: assert property (gate_o && $fell(rts_o) |-> txd_o && hi_cnt_r >= bit_div(rate_o))
    else $error("rts dropped before stop bit left");
endmodule
bind oobrts_tx oobrts_tx_properties #(.DEPTH(DEPTH)) u_props (.clk_i(clk_i), .rst_i(rst_i),
  .cfg_we_i(cfg_we_i), .cfg_rate_i(cfg_rate_i), .cfg_gate_i(cfg_gate_i),
  .selftest_done_i(selftest_done_i), .tx_data_i(tx_data_i), .tx_valid_i(tx_valid_i),
  .tx_ready_o(tx_ready_o), .txd_o(txd_o), .rts_o(rts_o), .rate_o(rate_o),
  .gate_o(gate_o), .busy_o(busy_o));
`default_nettype wire

// ===== verification/oobrts_modem.sv
// oobrts_modem: far-end receiver sampling the line mid-bit.
// assumes the port runs at 38400 baud; other rates are not decoded.
`timescale 1ns/1ps
`default_nettype none
module oobrts_modem
  import oobrts_pkg::*;
(
  input wire logic clk_i, // clock
  input wire logic txd_i, // line in
  output logic [7:0] byte_o, // received byte
  output logic stb_o // byte strobe
);
  initial begin
    stb_o = 1'b0;
    byte_o = 8'h00;
    forever begin
      @(negedge txd_i);
      // same bit time as the port
      repeat (DIV_38400 / 2) @(posedge clk_i);
      for (int k = 0; k < 8; k++) begin
        repeat (DIV_38400) @(posedge clk_i);
        byte_o[k] <= txd_i;
      end
      repeat (DIV_38400) @(posedge clk_i);
      stb_o <= (txd_i === 1'b1);
      @(posedge clk_i);
      stb_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== verification/oobrts_tx_tb.sv
// oobrts_tx_tb: self-checking bench for oobrts_tx.
// assumes the checker is bound from its own file.
`timescale 1ns/1ps
`default_nettype none
module oobrts_tx_tb;
  import oobrts_pkg::*;
  logic clk_i, rst_i, cfg_we_i, cfg_gate_i, selftest_done_i, tx_valid_i;
  logic [2:0] cfg_rate_i, r;
  logic [7:0] tx_data_i, b;
  wire logic tx_ready_o, txd_o, rts_o, gate_o, busy_o, rx_stb;
  wire logic [2:0] rate_o;
  wire logic [7:0] rx_byte;
  int err_total, cmp_count, seed, n, i;
  logic [2:0] exp_rate;
  logic [7:0] exp_q[$];
  oobrts_tx dut (.clk_i(clk_i), .rst_i(rst_i), .cfg_we_i(cfg_we_i), .cfg_rate_i(cfg_rate_i),
    .cfg_gate_i(cfg_gate_i), .selftest_done_i(selftest_done_i), .tx_data_i(tx_data_i),
    .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o), .txd_o(txd_o), .rts_o(rts_o),
    .rate_o(rate_o), .gate_o(gate_o), .busy_o(busy_o));
  oobrts_modem far (.clk_i(clk_i), .txd_i(txd_o), .byte_o(rx_byte), .stb_o(rx_stb));
  // =====
  // tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    cmp_count++;
    if (seen !== want) begin
      err_total++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask
  task automatic close_out();
    if (err_total == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic reset_chk();
    rst_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    check(rate_o, 3'h2);
    check(gate_o, 1'b0);
    check({txd_o, rts_o}, 2'h2);
    exp_rate = 3'h2;
  endtask
  task automatic cfg(input logic [2:0] rt, input logic g);
    cfg_rate_i <= rt;
    cfg_gate_i <= g;
    cfg_we_i <= 1'b1;
    @(posedge clk_i);
    cfg_we_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    if (rt <= 3'h4) exp_rate = rt;
    check(rate_o, exp_rate);
    check(gate_o, g);
  endtask
  task automatic selftest();
    selftest_done_i <= 1'b1;
    @(posedge clk_i);
    selftest_done_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    check({gate_o, rts_o}, 2'h1);
  endtask
  // =====
  // far-end bytes against the queue
  always @(posedge clk_i) begin
    if (rx_stb === 1'b1 && exp_q.size() > 0) check(rx_byte, exp_q.pop_front());
  end
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // =====
  // main sequence
  initial begin
    {rst_i, cfg_we_i, cfg_gate_i, selftest_done_i, tx_valid_i} = 5'h10;
    {cfg_rate_i, tx_data_i} = 11'h000;
    {err_total, cmp_count, seed} = {32'h0, 32'h0, 32'hAF0245DD};
    reset_chk();
    selftest();
    // codes 0..4 then an unused code, which must leave the rate alone
    for (i = 0; i < 6; i++) begin
      r = (i == 5) ? 3'h5 : i[2:0];
      b = 8'($random(seed));
      cfg(r, b[0]);
    end
    cfg(3'h4, 1'b1);
    check(rts_o, 1'b0);
    // two back-to-back bytes; rts must span both and fall after the last stop bit
    for (i = 0; i < 2; i++) begin
      b = 8'($random(seed));
      exp_q.push_back(b);
      tx_data_i <= b;
      tx_valid_i <= 1'b1;
      @(posedge clk_i);
    end
    tx_valid_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    check({busy_o, rts_o}, 2'h3);
    for (n = 0; n < 60000 && busy_o !== 1'b0; n++) @(posedge clk_i);
    if (n == 60000) begin
      err_total++;
      close_out();
    end
    repeat (3) @(posedge clk_i);
    check({txd_o, rts_o}, 2'h2);
    check(8'(exp_q.size()), 8'h00);
    // fill until refused; draining would take too long at these rates
    tx_valid_i <= 1'b1;
    n = 0;
    for (i = 0; i < 60; i++) begin
      @(posedge clk_i);
      if (tx_ready_o === 1'b1) n++;
      tx_data_i <= 8'($random(seed));
    end
    tx_valid_i <= 1'b0;
    check(tx_ready_o, 1'b0);
    check(8'(n), 8'(FIFO_DEPTH + 1));
    selftest();
    reset_chk();
    close_out();
  end
endmodule
`default_nettype wire
